// ===== hdl/mls_pkg.sv
// Purpose: Constants and types of the measurement loop sequencer.
// Assumes: Avalon-MM slave, 32-bit data, 16-bit registers in low half.
// Notes: Register map, control bits and command words.
package mls_pkg;

  localparam int unsigned RW = 16;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PRE  = 8'h04;
  localparam logic [7:0] A_TDLY = 8'h08;
  localparam logic [7:0] A_BLK  = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_DATA = 8'h14;
  localparam logic [7:0] A_FCNT = 8'h18;

  localparam int unsigned C_CONT  = 0;
  localparam int unsigned C_INH   = 1;
  localparam int unsigned C_STRIG = 2;
  localparam int unsigned C_PORT  = 3;
  localparam int unsigned C_CSYNC = 8;
  localparam int unsigned C_CSTOP = 9;

  localparam logic [7:0]  CH_LF    = 8'h0a;
  localparam logic [7:0]  CH_SEMI  = 8'h3b;
  localparam logic [31:0] CMD_SYNC = 32'h5359_4e43;
  localparam logic [31:0] CMD_STOP = 32'h5354_4f50;
  localparam logic [31:0] CMD_RST  = 32'h2a52_5354;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_TRIG,
    ST_MEAS
  } mls_state_e;

  typedef struct packed {
    logic port;
    logic strig;
    logic inh;
    logic cont;
  } mls_cfg_s;

  typedef struct packed {
    logic          read;
    logic          write;
    logic [7:0]    address;
    logic [31:0]   writedata;
    logic [3:0]    byteenable;
  } mls_av_req_s;

endpackage

// ===== hdl/mls_seq.sv
// Purpose: Acquisition sequencer driven by the shared open-drain sync line.
// Assumes: Inputs other than i_sync_i synchronous to i_clk; sync asserted when line is low.
// Notes: Sample FIFO inside; port 0 is the bus data register, port 1 stream.
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module mls_seq
  import mls_pkg::*;
#(
  parameter int unsigned AW    = 10,
  parameter int unsigned DEC_W = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  input  wire mls_av_req_s   i_av,
  output logic               o_waitrequest,
  output logic [31:0]        o_readdata,
  input  wire logic          i_sync_i,
  output logic               o_sync_o,
  output logic               o_sync_oe,
  input  wire logic          i_smp_valid,
  input  wire logic [RW-1:0] i_smp_data,
  input  wire logic          i_trig,
  output logic               o_str_valid,
  output logic [RW-1:0]      o_str_data,
  input  wire logic          i_str_ready,
  input  wire logic          i_chr_valid,
  input  wire logic [7:0]    i_chr_data,
  output logic [1:0]         o_state,
  output logic               o_ovf,
  output logic [DEC_W-1:0]   o_dec_cnt,
  output logic               o_lo_rst
);

  localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

  typedef struct packed {
    mls_state_e        st;
    mls_cfg_s          cfg;
    logic [RW-1:0]     pre;
    logic [RW-1:0]     tdly;
    logic [RW-1:0]     blk;
    logic [AW-1:0]     wr;
    logic [AW-1:0]     rd;
    logic [AW:0]       cnt;
    logic [RW-1:0]     skip;
    logic [RW:0]       got;
    logic              ovf;
    logic              drive;
    logic              lvl;
    logic              s1;
    logic              s2;
    logic              s3;
    logic              wreq;
    logic [RW-1:0]     rdata;
    logic              sv;
    logic [RW-1:0]     sd;
    logic [31:0]       chr;
    logic [DEC_W-1:0]  dec;
    logic              lor;
  } mls_st_s;

  mls_st_s       q;
  mls_st_s       d;
  logic [RW-1:0] mem [0:(1<<AW)-1];
  logic          push;
  logic [RW-1:0] head;

  assign head = mem[q.rd];

  function automatic logic [RW-1:0] merge(input logic [RW-1:0] old,
                                          input logic [31:0]   wd,
                                          input logic [3:0]    be);
    merge = old;
    if (be[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  always_comb begin
    logic          req;
    logic          ack;
    logic          rise;
    logic          fall;
    logic          csync;
    logic          cstop;
    logic          crst;
    logic          pop;
    logic          full;
    logic          ready;
    logic          done;
    logic [RW-1:0] rv;
    logic [RW-1:0] cw;
    d     = q;
    rise  = 1'b0;
    fall  = 1'b0;
    done  = 1'b0;
    csync = 1'b0;
    cstop = 1'b0;
    crst  = 1'b0;
    pop   = 1'b0;
    push  = 1'b0;
    rv    = '0;
    cw    = '0;
    req   = i_av.read | i_av.write;
    ack   = req & ~q.wreq;
    full  = (q.cnt == DEPTH);
    ready = (q.st == ST_IDLE || q.st == ST_MEAS) && q.skip == '0
            && q.cnt != '0;

    // Two-stage synchroniser, third stage only for edges
    d.s1 = ~i_sync_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    rise = q.s2 & ~q.s3;
    fall = ~q.s2 & q.s3;

    d.lor = 1'b0;
    d.dec = q.dec + 1'b1;
    if (rise | fall) begin
      d.dec = '0;
      d.lor = 1'b1;
    end

    // Avalon slave: one wait cycle, then accept
    d.wreq = 1'b1;
    if (req & q.wreq) begin
      d.wreq = 1'b0;
      unique case (i_av.address)
        A_CTRL:  rv = {12'h000, q.cfg};
        A_PRE:   rv = q.pre;
        A_TDLY:  rv = q.tdly;
        A_BLK:   rv = q.blk;
        A_STAT:  rv = {12'h000, q.drive, q.ovf, q.st};
        A_DATA:  rv = (!q.cfg.port && ready) ? head : '0;
        A_FCNT:  rv = RW'(q.cnt);
        default: rv = '0;
      endcase
      d.rdata = rv;
    end
    if (ack & i_av.write) begin
      unique case (i_av.address)
        A_CTRL: begin
          cw    = merge({12'h000, q.cfg}, i_av.writedata, i_av.byteenable);
          d.cfg = cw[3:0];
          csync = i_av.byteenable[1] & i_av.writedata[C_CSYNC];
          cstop = i_av.byteenable[1] & i_av.writedata[C_CSTOP];
        end
        A_PRE:   d.pre  = merge(q.pre, i_av.writedata, i_av.byteenable);
        A_TDLY:  d.tdly = merge(q.tdly, i_av.writedata, i_av.byteenable);
        A_BLK:   d.blk  = merge(q.blk, i_av.writedata, i_av.byteenable);
        default: ;
      endcase
    end
    if (ack & i_av.read & (i_av.address == A_DATA) & ~q.cfg.port & ready)
    begin
      pop = 1'b1;
    end

    // ASCII commands, terminated by newline or semicolon
    if (i_chr_valid) begin
      if (i_chr_data == CH_LF || i_chr_data == CH_SEMI) begin
        csync = csync | (q.chr == CMD_SYNC);
        cstop = cstop | (q.chr == CMD_STOP);
        crst  = (q.chr == CMD_RST);
        d.chr = '0;
      end else begin
        d.chr = {q.chr[23:0], i_chr_data};
      end
    end

    // Stream port
    if (i_str_ready) begin
      d.sv = 1'b0;
    end
    if (q.cfg.port && ready && (!q.sv || i_str_ready)) begin
      pop  = 1'b1;
      d.sv = 1'b1;
      d.sd = head;
    end

    push = i_smp_valid && q.st != ST_IDLE && !full;
    done = !q.cfg.cont && (q.got >= ({1'b0, q.tdly} + {1'b0, q.blk})
           || full);

    unique case (q.st)
      ST_IDLE: begin
        if (csync) begin
          d.drive = 1'b1;
        end
        if (rise && !q.cfg.inh) begin
          d.st    = ST_ARM;
          d.ovf   = 1'b0;
          d.drive = (q.pre != '0);
        end
      end
      ST_ARM: begin
        if (q.drive && (RW+1)'(q.cnt) >= {1'b0, q.pre}) begin
          d.drive = 1'b0;
        end
        if (fall) begin
          d.st = ST_TRIG;
        end
      end
      ST_TRIG: begin
        if (push && q.cnt != '0 && (RW+1)'(q.cnt) >= {1'b0, q.pre}) begin
          pop = 1'b1;
        end
        if (csync || (q.cfg.strig && i_trig)) begin
          d.drive = 1'b1;
        end
        if (rise) begin
          d.st    = ST_MEAS;
          d.got   = '0;
          d.skip  = q.tdly;
          d.drive = !q.cfg.cont;
        end
      end
      ST_MEAS: begin
        if (q.skip != '0 && q.cnt != '0) begin
          pop    = 1'b1;
          d.skip = q.skip - 1'b1;
        end
        if (push) begin
          d.got = q.got + 1'b1;
        end
        if (q.cfg.cont && i_smp_valid && full) begin
          d.ovf = 1'b1;
          d.st  = ST_IDLE;
        end
        if (done) begin
          d.drive = 1'b0;
          d.st    = ST_IDLE;
        end
      end
      default: ;
    endcase

    if (cstop) begin
      d.drive = 1'b0;
      d.st    = ST_IDLE;
    end

    if (push) begin
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);

    if (q.st == ST_IDLE && d.st == ST_ARM) begin
      d.wr  = '0;
      d.rd  = '0;
      d.cnt = '0;
      d.sv  = 1'b0;
    end

    if (crst) begin
      d.cfg   = '0;
      d.pre   = '0;
      d.tdly  = '0;
      d.blk   = '0;
      d.drive = 1'b0;
      d.st    = ST_IDLE;
    end
  end

  // Sync drive only moves at clock edges, clear of capture window
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      q      <= '0;
      q.wreq <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[q.wr] <= i_smp_data;
    end
  end

  assign o_waitrequest = q.wreq;
  assign o_readdata    = {16'h0000, q.rdata};
  assign o_sync_o      = q.lvl;
  assign o_sync_oe     = q.drive;
  assign o_str_valid   = q.sv;
  assign o_str_data    = q.sd;
  assign o_state       = q.st;
  assign o_ovf         = q.ovf;
  assign o_dec_cnt     = q.dec;
  assign o_lo_rst      = q.lor;

endmodule
`default_nettype wire

// ===== verif/mls_peer.sv
// Purpose: Second module sharing the open-drain sync line.
// Assumes: Line low means asserted.
// Notes: Keeps pulling HOLD cycles after its pull request ends.
`timescale 1ns/1ps
`default_nettype none
module mls_peer #(
  parameter int unsigned HOLD = 4
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_pull,
  output logic      o_oe
);
  logic [7:0] cnt_q;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_q <= 8'h00;
      o_oe  <= 1'b0;
    end else begin
      if (i_pull) cnt_q <= 8'(HOLD);
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
      // Drive only from a clock edge
      o_oe <= i_pull || cnt_q != 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== verif/mls_seq_assertions.sv
// Purpose: Port checks of the sync sequencer.
// Assumes: Line low means asserted.
// Notes: Config tracked from accepted writes.
`timescale 1ns/1ps
`default_nettype none
module mls_seq_assertions
  import mls_pkg::*;
#(
  parameter int unsigned DEC_W = 8
) (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire mls_av_req_s i_av,
  input wire logic        o_waitrequest,
  input wire logic        i_sync_i,
  input wire logic        o_sync_oe,
  input wire logic [1:0]  o_state,
  input wire logic        o_ovf,
  input wire logic [DEC_W-1:0] o_dec_cnt,
  input wire logic        o_lo_rst
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  logic [5:0] sh_q;
  logic [1:0] ps_q;
  logic       pre0_q;
  logic       cont_q;
  logic       ent_a;
  logic       ent_m;
  assign ent_a = o_state == ST_ARM && ps_q != ST_ARM;
  assign ent_m = o_state == ST_MEAS && ps_q != ST_MEAS;
  always_ff @(posedge i_clk) begin
    sh_q <= {sh_q[4:0], i_sync_i};
    ps_q <= o_state;
    if (!i_nrst) begin
      pre0_q <= 1'b1;
      cont_q <= 1'b0;
    end else if (i_av.write && !o_waitrequest) begin
      if (i_av.address == A_PRE) pre0_q <= i_av.writedata[15:0] == 16'h0000;
      if (i_av.address == A_CTRL) cont_q <= i_av.writedata[C_CONT];
    end
  end
  chk_bus_answer:
  assert property ((i_av.read || i_av.write) && o_waitrequest
    |=> !o_waitrequest ##1 o_waitrequest) else $error("bus answer");
  chk_sync_cause:
  assert property ($changed(o_state) && o_state != ST_IDLE
    |-> sh_q != 6'h00 && sh_q != 6'h3f) else $error("no sync edge");
  chk_idle_exit:
  assert property (ps_q == ST_IDLE && o_state != ST_IDLE
    |-> o_state == ST_ARM) else $error("idle exit");
  chk_arm_exit:
  assert property (ps_q == ST_ARM && o_state == ST_TRIG
    |-> sh_q[1:0] == 2'b11) else $error("arm exit");
  chk_trig_exit:
  assert property (ps_q == ST_TRIG && o_state == ST_MEAS
    |-> sh_q[1:0] == 2'b00) else $error("trigger exit");
  chk_pre_drive:
  assert property (ent_a |-> o_sync_oe == !pre0_q) else $error("arm drive");
  chk_meas_drive:
  assert property (ent_m |-> o_sync_oe == !cont_q) else $error("meas drive");
  chk_ovf_sticky:
  assert property ($fell(o_ovf) |-> ent_a) else $error("ovf cleared");
  chk_lo_align:
  assert property (o_lo_rst == (sh_q[2] != sh_q[3])
    && (o_lo_rst -> o_dec_cnt == '0)) else $error("phase align");
  chk_dec_count:
  assert property ($past(i_nrst) && !o_lo_rst
    |-> o_dec_cnt - $past(o_dec_cnt) == DEC_W'(1)) else $error("dec count");
  cover property (ent_m && cont_q);
  cover property (ps_q == ST_MEAS && o_state == ST_IDLE);
  cover property ($rose(o_ovf));
endmodule
bind mls_seq mls_seq_assertions #(.DEC_W(DEC_W)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_av(i_av),
  .o_waitrequest(o_waitrequest), .i_sync_i(i_sync_i),
  .o_sync_oe(o_sync_oe), .o_state(o_state), .o_ovf(o_ovf),
  .o_dec_cnt(o_dec_cnt), .o_lo_rst(o_lo_rst));
`default_nettype wire

// ===== verif/test_mls_seq.sv
// Purpose: Self-checking bench of the sync sequencer.
// Assumes: Line pulled up; one peer on it.
// Notes: FIFO depth cut to 16.
`timescale 1ns/1ps
`default_nettype none
module test_mls_seq;
  import mls_pkg::*;
  logic          clk = 1'b0;
  logic          nrst = 1'b0;
  logic          trig = 1'b0;
  logic          sv = 1'b0;
  logic          cv = 1'b0;
  logic          rdy = 1'b0;
  logic          pull = 1'b0;
  logic [RW-1:0] sd = 16'h0000;
  logic [RW-1:0] nxt;
  logic [RW-1:0] b;
  logic [7:0]    cd = 8'h00;
  mls_av_req_s   av = '0;
  logic          wq;
  logic [31:0]   rd;
  logic          oe;
  logic          p_oe;
  logic          line;
  logic          s_v;
  logic [RW-1:0] s_d;
  logic [RW-1:0] str_q[$];
  logic [31:0]   exp_q[$];
  logic [31:0]   msk_q[$];
  int            bad_count = 0;
  int            checked = 0;
  integer        seed = 32'h3eec;
  assign line = !(oe || p_oe);
  mls_seq #(.AW(4), .DEC_W(8)) DUT (
    .i_clk(clk), .i_nrst(nrst), .i_av(av), .o_waitrequest(wq),
    .o_readdata(rd), .i_sync_i(line), .o_sync_o(), .o_sync_oe(oe),
    .i_smp_valid(sv), .i_smp_data(sd), .i_trig(trig), .o_str_valid(s_v),
    .o_str_data(s_d), .i_str_ready(rdy), .i_chr_valid(cv), .i_chr_data(cd),
    .o_state(), .o_ovf(), .o_dec_cnt(), .o_lo_rst());
  mls_peer #(.HOLD(4)) u_peer (
    .i_clk(clk), .i_nrst(nrst), .i_pull(pull), .o_oe(p_oe));
  initial forever #50 clk = ~clk;
  task automatic complete_run;
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, m, g);
    checked++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("unexpected readdata exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_str(input logic [RW-1:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected stream data exp %h got %h", e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    av <= '{!w, w, a, {16'h0000, d}, 4'h3};
    do @(posedge clk); while (wq !== 1'b0);
    av <= '0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [15:0] e, m);
    exp_q.push_back({16'h0000, e});
    msk_q.push_back({16'hffff, m});
    bus(1'b0, a, 16'h0000);
  endtask
  task automatic smp(input int n);
    repeat (n) begin
      @(posedge clk);
      sv  <= 1'b1;
      sd  <= nxt;
      nxt <= nxt + 16'h0001;
      rdy <= 1'($random(seed));
    end
    @(posedge clk);
    sv <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] s);
    for (int i = 3; i >= -1; i--) begin
      @(posedge clk);
      cv <= 1'b1;
      cd <= (i < 0) ? CH_LF : s[8*i +: 8];
    end
    @(posedge clk);
    cv <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (av.read && wq === 1'b0 && exp_q.size() > 0) begin
      cmp(exp_q.pop_front(), msk_q.pop_front(), rd);
    end
  end
  always @(posedge clk) begin
    if (s_v === 1'b1 && rdy === 1'b1) begin
      if (str_q.size() > 0) begin
        cmp_str(str_q.pop_front(), s_d);
      end else begin
        bad_count++;
        $display("unexpected stream beat exp none got %h", s_d);
      end
    end
  end
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    nxt = 16'($random(seed));
    cyc(16);
    nrst <= 1'b1;
    bus(1'b1, A_PRE, 16'h0003);
    bus(1'b1, A_TDLY, 16'h0000);
    bus(1'b1, A_BLK, 16'h0004);
    bus(1'b1, A_CTRL, 16'h0000);
    rdx(A_STAT, 16'h0000, 16'h000f);
    pull <= 1'b1;
    cyc(8);
    rdx(A_STAT, 16'h0009, 16'h000f);
    rdx(A_FCNT, 16'h0000, 16'hffff);
    smp(3);
    cyc(4);
    rdx(A_STAT, 16'h0001, 16'h000f);
    pull <= 1'b0;
    cyc(12);
    rdx(A_STAT, 16'h0002, 16'h000f);
    b = nxt;
    smp(10);
    rdx(A_FCNT, 16'h0003, 16'hffff);
    cmd(CMD_SYNC);
    cyc(6);
    rdx(A_STAT, 16'h000b, 16'h000f);
    smp(4);
    cyc(6);
    rdx(A_STAT, 16'h0000, 16'h000f);
    smp(5);
    for (int i = 7; i < 14; i++) rdx(A_DATA, b + 16'(i), 16'hffff);
    rdx(A_DATA, 16'h0000, 16'hffff);
    bus(1'b1, A_CTRL, 16'h0002);
    pull <= 1'b1;
    cyc(8);
    rdx(A_STAT, 16'h0000, 16'h0003);
    pull <= 1'b0;
    cyc(12);
    bus(1'b1, A_PRE, 16'h0000);
    bus(1'b1, A_CTRL, 16'h0005);
    rdx(A_CTRL, 16'h0005, 16'h030f);
    rdx(8'h1c, 16'h0000, 16'hffff);
    pull <= 1'b1;
    cyc(2);
    pull <= 1'b0;
    cyc(12);
    rdx(A_STAT, 16'h0002, 16'h000f);
    trig <= 1'b1;
    cyc(8);
    trig <= 1'b0;
    rdx(A_STAT, 16'h0003, 16'h000f);
    smp(20);
    cyc(4);
    rdx(A_STAT, 16'h0004, 16'h000f);
    pull <= 1'b1;
    cyc(2);
    pull <= 1'b0;
    cyc(4);
    rdx(A_STAT, 16'h0000, 16'h0004);
    cyc(8);
    bus(1'b1, A_CTRL, 16'h0105);
    cyc(6);
    rdx(A_STAT, 16'h0003, 16'h0007);
    cmd(CMD_STOP);
    cyc(4);
    rdx(A_STAT, 16'h0000, 16'h0003);
    bus(1'b1, A_CTRL, 16'h0008);
    smp(8);
    rdx(A_FCNT, 16'h0000, 16'hffff);
    pull <= 1'b1;
    cyc(2);
    pull <= 1'b0;
    cyc(12);
    bus(1'b1, A_CTRL, 16'h0108);
    cyc(6);
    rdx(A_STAT, 16'h000b, 16'h000f);
    for (int i = 0; i < 4; i++) str_q.push_back(nxt + 16'(i));
    smp(4);
    rdy <= 1'b1;
    cyc(8);
    rdx(A_STAT, 16'h0000, 16'h000f);
    cmp_str(16'h0000, 16'(str_q.size()));
    complete_run();
  end
endmodule
`default_nettype wire
